// [hdl/tmpic_consts.vh]
// Constants for the PWM timer and interval timer block.
// Included by the design files; holds definitions only.
`ifndef TMPIC_CONSTS_VH
`define TMPIC_CONSTS_VH

// ----------------------------------------------------------------
// Count source select codes
// ----------------------------------------------------------------
`define TMPIC_SRC_DIV1 2'h0
`define TMPIC_SRC_DIV8 2'h1
`define TMPIC_SRC_DIV32 2'h2
`define TMPIC_SRC_SUB32 2'h3

// ----------------------------------------------------------------
// Prescaler divide counts
// ----------------------------------------------------------------
`define TMPIC_DIV8_LAST 5'h07
`define TMPIC_DIV32_LAST 5'h1f

// ----------------------------------------------------------------
// PWM start source select codes
// ----------------------------------------------------------------
`define TMPIC_TRG_SOFT 2'h0
`define TMPIC_TRG_PIN 2'h1
`define TMPIC_TRG_OVF 2'h2

// ----------------------------------------------------------------
// Input-capable channel mode codes (mode register bits 1:0)
// ----------------------------------------------------------------
`define TMPIC_MODE_TIMER 2'h0
`define TMPIC_MODE_EVENT 2'h1
`define TMPIC_MODE_MEASURE 2'h2

// ----------------------------------------------------------------
// Channel count, counter reset value and fixed PWM periods
// ----------------------------------------------------------------
`define TMPIC_NUM_CH 6
`define TMPIC_CNT_RESET 16'h0000
`define TMPIC_PWM_PERIOD16 16'hffff
`define TMPIC_PWM_PERIOD8 8'hff

`endif

// [hdl/tmpic_interval_chan.v]
// One input-capable timer channel in interval timer mode.
// Assumes a one-cycle count tick from the parent, same clock domain.
`timescale 1ns/1ps
`include "tmpic_consts.vh"

module tmpic_interval_chan
(
  input wire CLK_I,
  input wire RESET_N_I,
  input wire tick_i,
  input wire [1:0] mode_i,
  input wire start_i,
  input wire wr_i,
  input wire [15:0] wdata_i,
  output wire [15:0] count_o,
  output wire irq_o
);

  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [15:0] reload_reg;
  reg irq_reg;
  reg irq_next;
  wire run;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Other modes are not built here; the channel stays idle in them
  assign run = start_i & (mode_i == `TMPIC_MODE_TIMER);

  always @*
  begin
    cnt_next = cnt_reg;
    irq_next = 1'b0;
    if (wr_i && !run)
      cnt_next = wdata_i;
    else if (run && tick_i)
    begin
      if (cnt_reg == 16'h0000)
      begin
        cnt_next = reload_reg;
        irq_next = 1'b1;
      end
      else
        cnt_next = cnt_reg - 16'h0001;
    end
  end

  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      cnt_reg <= `TMPIC_CNT_RESET;
      reload_reg <= `TMPIC_CNT_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      irq_reg <= irq_next;
      if (wr_i)
        reload_reg <= wdata_i;
    end
  end

  assign count_o = cnt_reg;
  assign irq_o = irq_reg;

endmodule // tmpic_interval_chan

// [hdl/tmpic_timer.v]
// Top of the timer block: one PWM channel and six interval channels.
// Assumes one 100 MHz clock; the sub clock (divided by 32 here) and the
// trigger pin come from outside and are synchronised here.
`timescale 1ns/1ps
`include "tmpic_consts.vh"

module tmpic_timer
#(
  parameter NUM_CH = `TMPIC_NUM_CH
)
(
  input wire CLK_I,
  input wire RESET_N_I,
  input wire SUB_CLOCK_DIV32_I,
  input wire [1:0] PWM_CLK_SEL_I,
  input wire PWM_MODE8_I,
  input wire [1:0] PWM_TRIG_SEL_I,
  input wire PWM_START_I,
  input wire PWM_OTHER_OVF_I,
  input wire PWM_TRIGGER_INPUT_PIN_I,
  input wire PWM_WR_I,
  input wire [15:0] PWM_WDATA_I,
  output wire [15:0] PWM_RDATA_O,
  output wire PWM_PULSE_OUTPUT_PIN_O,
  output wire PWM_IRQ_O,
  input wire [2*NUM_CH-1:0] TB_CLK_SEL_I,
  input wire [2*NUM_CH-1:0] TB_MODE_I,
  input wire [NUM_CH-1:0] TB_START_I,
  input wire [NUM_CH-1:0] TB_WR_I,
  input wire [16*NUM_CH-1:0] TB_WDATA_I,
  output wire [16*NUM_CH-1:0] TB_COUNT_O,
  output wire [NUM_CH-1:0] TB_IRQ_O
);

  reg [4:0] pre_reg;
  reg [2:0] sub_sync_reg;
  reg [1:0] trg_sync_reg;
  reg trg_prev_reg;
  reg [4:0] sub_cnt_reg;
  reg sub_tick_reg;
  wire sub_edge;
  wire tick_div1;
  wire tick_div8;
  wire tick_div32;
  wire [3:0] ticks;
  wire pwm_tick;
  wire trig_edge;

  // ----------------------------------------------------------------
  // Count source prescalers
  // ----------------------------------------------------------------
  // Sub clock is slow and asynchronous: two flops, then edge detect
  assign sub_edge = sub_sync_reg[1] & ~sub_sync_reg[2];
  assign tick_div1 = 1'b1;
  assign tick_div8 = (pre_reg[2:0] == `TMPIC_DIV8_LAST);
  assign tick_div32 = (pre_reg == `TMPIC_DIV32_LAST);
  assign ticks = {sub_tick_reg, tick_div32, tick_div8, tick_div1};

  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      pre_reg <= 5'h00;
      sub_sync_reg <= 3'h0;
      sub_cnt_reg <= 5'h00;
      sub_tick_reg <= 1'b0;
      trg_sync_reg <= 2'h0;
      trg_prev_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_reg + 5'h01;
      sub_sync_reg <= {sub_sync_reg[1:0], SUB_CLOCK_DIV32_I};
      sub_tick_reg <= 1'b0;
      if (sub_edge)
      begin
        sub_cnt_reg <= sub_cnt_reg + 5'h01;
        sub_tick_reg <= (sub_cnt_reg == `TMPIC_DIV32_LAST);
      end
      trg_sync_reg <= {trg_sync_reg[0], PWM_TRIGGER_INPUT_PIN_I};
      trg_prev_reg <= trg_sync_reg[1];
    end
  end

  assign pwm_tick = ticks[PWM_CLK_SEL_I];

  // ----------------------------------------------------------------
  // PWM channel
  // ----------------------------------------------------------------
  assign trig_edge = trg_sync_reg[1] & ~trg_prev_reg;

  reg run_reg;
  reg run_next;
  reg out_reg;
  reg out_next;
  reg irq_reg;
  reg irq_next;
  reg [15:0] reload_reg;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [7:0] pre8_reg;
  reg [7:0] pre8_next;
  reg pend_reg;
  reg pend_next;
  reg start_cond;
  wire [7:0] hi_n;
  wire [7:0] lo_m;

  assign hi_n = reload_reg[15:8];
  assign lo_m = reload_reg[7:0];

  always @*
  begin
    case (PWM_TRIG_SEL_I)
      `TMPIC_TRG_PIN: start_cond = trig_edge;
      `TMPIC_TRG_OVF: start_cond = PWM_OTHER_OVF_I;
      `TMPIC_TRG_SOFT: start_cond = 1'b1;
      default: start_cond = 1'b1;
    endcase
  end

  // cnt_reg counts down from the period, the position being period - cnt + 1; the pulse is high while the
  // position is not above the high width. In 8-bit mode pre8 prescales by
  // m+1 and cnt counts 255 prescaled steps.
  always @*
  begin
    run_next = run_reg;
    out_next = out_reg;
    irq_next = 1'b0;
    cnt_next = cnt_reg;
    pre8_next = pre8_reg;
    pend_next = pend_reg;
    if (!PWM_START_I)
    begin
      run_next = 1'b0;
      out_next = 1'b0;
      pend_next = 1'b0;
      if (PWM_WR_I)
        cnt_next = PWM_WDATA_I;
    end
    else if (!run_reg)
    begin
      // Waiting for start; a write here still loads both
      if (PWM_WR_I)
        cnt_next = PWM_WDATA_I;
      // A start event is held until the next count tick, so the
      // first pulse is a whole number of count clock periods
      if (start_cond)
        pend_next = 1'b1;
      if ((start_cond || pend_reg) && pwm_tick)
      begin
        run_next = 1'b1;
        pend_next = 1'b0;
        cnt_next = PWM_MODE8_I ? {8'h00, `TMPIC_PWM_PERIOD8} :
          `TMPIC_PWM_PERIOD16;
        pre8_next = lo_m;
        out_next = PWM_MODE8_I ? (hi_n != 8'h00) :
          (reload_reg != 16'h0000);
      end
    end
    else if (pwm_tick)
    begin
      if (PWM_MODE8_I && pre8_reg != 8'h00)
        pre8_next = pre8_reg - 8'h01;
      else
      begin
        pre8_next = lo_m;
        if (cnt_reg <= 16'h0001)
        begin
          // Period end: rising edge, fresh count from the fixed period
          cnt_next = PWM_MODE8_I ? {8'h00, `TMPIC_PWM_PERIOD8} :
            `TMPIC_PWM_PERIOD16;
          out_next = PWM_MODE8_I ? (hi_n != 8'h00) :
            (reload_reg != 16'h0000);
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
          if (PWM_MODE8_I)
            out_next = ((`TMPIC_PWM_PERIOD8 - cnt_next[7:0] + 8'h01)
              <= hi_n) && (hi_n != 8'h00);
          else
            out_next = ((`TMPIC_PWM_PERIOD16 - cnt_next + 16'h0001)
              <= reload_reg) && (reload_reg != 16'h0000);
        end
      end
    end
    if (out_reg && !out_next && run_reg)
      irq_next = 1'b1;
  end

  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      run_reg <= 1'b0;
      out_reg <= 1'b0;
      irq_reg <= 1'b0;
      cnt_reg <= `TMPIC_CNT_RESET;
      pre8_reg <= 8'h00;
      pend_reg <= 1'b0;
      reload_reg <= `TMPIC_CNT_RESET;
    end
    else
    begin
      run_reg <= run_next;
      out_reg <= out_next;
      irq_reg <= irq_next;
      cnt_reg <= cnt_next;
      pre8_reg <= pre8_next;
      pend_reg <= pend_next;
      // Running writes reach only reload; used from the next count tick
      if (PWM_WR_I)
        reload_reg <= PWM_WDATA_I;
    end
  end

  // Count is not meaningful to software in this mode; reads give zero
  assign PWM_RDATA_O = 16'h0000;
  assign PWM_PULSE_OUTPUT_PIN_O = out_reg;
  assign PWM_IRQ_O = irq_reg;

  // ----------------------------------------------------------------
  // Interval timer channels
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1)
    begin : g_chan
      wire tb_tick;
      assign tb_tick = ticks[TB_CLK_SEL_I[2*gi+1:2*gi]];
      tmpic_interval_chan u_chan
      (
        .CLK_I(CLK_I),
        .RESET_N_I(RESET_N_I),
        .tick_i(tb_tick),
        .mode_i(TB_MODE_I[2*gi+1:2*gi]),
        .start_i(TB_START_I[gi]),
        .wr_i(TB_WR_I[gi]),
        .wdata_i(TB_WDATA_I[16*gi+15:16*gi]),
        .count_o(TB_COUNT_O[16*gi+15:16*gi]),
        .irq_o(TB_IRQ_O[gi])
      );
    end
  endgenerate

endmodule // tmpic_timer

// [tb/tmpic_timer_asserts.sv]
// Checker for the ports of the timer block top.
// Assumes one clock and the reset of that domain; bound below.
`timescale 1ns/1ps
module tmpic_timer_asserts #(parameter NUM_CH = 6)
(
  input wire CLK_I,
  input wire RESET_N_I,
  input wire PWM_START_I,
  input wire [15:0] PWM_RDATA_O,
  input wire PWM_PULSE_OUTPUT_PIN_O,
  input wire PWM_IRQ_O,
  input wire [2*NUM_CH-1:0] TB_CLK_SEL_I,
  input wire [2*NUM_CH-1:0] TB_MODE_I,
  input wire [NUM_CH-1:0] TB_START_I,
  input wire [NUM_CH-1:0] TB_WR_I,
  input wire [16*NUM_CH-1:0] TB_WDATA_I,
  input wire [16*NUM_CH-1:0] TB_COUNT_O,
  input wire [NUM_CH-1:0] TB_IRQ_O
);
  wire [15:0] c0 = TB_COUNT_O[15:0];
  // Channel 0 counting on the full-rate clock, no write pending
  wire run0 = TB_START_I[0] && !TB_WR_I[0] && TB_MODE_I[1:0] == 2'h0
    && TB_CLK_SEL_I[1:0] == 2'h0;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  a_rdata_undef: assert property (PWM_RDATA_O == 16'h0000)
    else $error("pwm read data not zero");
  a_irq_on_fall: assert property (
    $fell(PWM_PULSE_OUTPUT_PIN_O) && PWM_START_I |-> ##[0:1] PWM_IRQ_O)
    else $error("no pwm request after pulse fall");
  a_irq_single: assert property (PWM_IRQ_O |=> !PWM_IRQ_O)
    else $error("pwm request longer than one cycle");
  a_stop_low: assert property (
    !PWM_START_I |=> !PWM_PULSE_OUTPUT_PIN_O)
    else $error("pulse high while stopped");
  a_itv_dec: assert property (
    run0 && $past(TB_START_I[0]) && c0 != 16'h0000
    |=> c0 == $past(c0) - 16'h0001)
    else $error("interval count did not step down");
  a_itv_underflow: assert property (
    run0 && $past(TB_START_I[0]) && c0 == 16'h0000 |-> ##[1:2] TB_IRQ_O[0])
    else $error("no request on underflow");
  a_itv_hold: assert property (
    !TB_START_I[0] && !TB_WR_I[0] |=> $stable(c0))
    else $error("stopped interval count moved");
  a_itv_load: assert property (
    TB_WR_I[0] && !TB_START_I[0] |=> c0 == $past(TB_WDATA_I[15:0]))
    else $error("stopped write did not load counter");
  cover property (TB_IRQ_O[0]);
  cover property ($fell(PWM_PULSE_OUTPUT_PIN_O));
  cover property (PWM_IRQ_O);
endmodule // tmpic_timer_asserts

bind tmpic_timer tmpic_timer_asserts #(.NUM_CH(NUM_CH)) chk_i (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PWM_START_I(PWM_START_I),
  .PWM_RDATA_O(PWM_RDATA_O), .PWM_IRQ_O(PWM_IRQ_O),
  .PWM_PULSE_OUTPUT_PIN_O(PWM_PULSE_OUTPUT_PIN_O),
  .TB_CLK_SEL_I(TB_CLK_SEL_I), .TB_MODE_I(TB_MODE_I),
  .TB_START_I(TB_START_I), .TB_WR_I(TB_WR_I), .TB_WDATA_I(TB_WDATA_I),
  .TB_COUNT_O(TB_COUNT_O), .TB_IRQ_O(TB_IRQ_O));

// [tb/tmpic_far_model.sv]
// Far side of the PWM channel: trigger source and pulse load.
// Assumes fire_i is a one-cycle request from the bench.
`timescale 1ns/1ps
module tmpic_far_model
(
  input wire clk_i,
  input wire fire_i,
  input wire pulse_i,
  output reg trig_o = 1'b0,
  output reg [31:0] high_o = 32'h0000_0000,
  output reg [31:0] per_o = 32'h0000_0000
);
  reg [2:0] hold = 3'h0;
  reg last = 1'b0;
  reg [31:0] cnt = 32'h0000_0000;
  // Trigger held five cycles so the pin survives the synchroniser
  always @(posedge clk_i)
  begin
    trig_o <= fire_i || hold != 3'h0;
    hold <= fire_i ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : hold);
    last <= pulse_i;
    cnt <= (pulse_i && !last) ? 32'h0000_0001 : cnt + 32'h0000_0001;
    if (pulse_i && !last)
      per_o <= cnt;
    if (!pulse_i && last)
      high_o <= cnt;
  end
endmodule // tmpic_far_model

// [tb/tb_top.sv]
// Self-checking bench for the PWM and interval timer block.
// Assumes six channels; inputs change at the falling clock edge.
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg sub = 1'b0;
  reg [1:0] csel = 2'h0;
  reg m8 = 1'b0;
  reg [1:0] tsel = 2'h0;
  reg pstart = 1'b0;
  reg ovf = 1'b0;
  reg pwr = 1'b0;
  reg [15:0] pwd = 16'h0000;
  reg fire = 1'b0;
  reg [11:0] t_csel = 12'h000;
  reg [11:0] t_mode = 12'h900;
  reg [5:0] t_start = 6'h00;
  reg [5:0] t_wr = 6'h00;
  reg [95:0] t_wd = 96'h0;
  reg refused = 1'b0;
  wire [15:0] prd;
  wire pout, pirq, trig;
  wire [95:0] t_cnt;
  wire [5:0] t_irq;
  wire [31:0] high, per;
  integer failures = 0;
  integer cmp_count = 0;
  integer irq_count = 0;
  integer k;
  always #5 clk = ~clk;
  // Sub clock of four system cycles, so its divide-by-32 is 128 cycles
  always #20 sub = ~sub;
  always @(negedge clk)
    if (t_irq[5:4] != 2'h0)
      refused = 1'b1;
  always @(negedge clk)
    if (pirq === 1'b1)
      irq_count = irq_count + 1;
  tmpic_timer tmpic_timer_i (.CLK_I(clk), .RESET_N_I(rst_n),
    .SUB_CLOCK_DIV32_I(sub), .PWM_CLK_SEL_I(csel), .PWM_MODE8_I(m8),
    .PWM_TRIG_SEL_I(tsel), .PWM_START_I(pstart), .PWM_OTHER_OVF_I(ovf),
    .PWM_TRIGGER_INPUT_PIN_I(trig), .PWM_WR_I(pwr), .PWM_WDATA_I(pwd),
    .PWM_RDATA_O(prd), .PWM_PULSE_OUTPUT_PIN_O(pout), .PWM_IRQ_O(pirq),
    .TB_CLK_SEL_I(t_csel), .TB_MODE_I(t_mode), .TB_START_I(t_start),
    .TB_WR_I(t_wr), .TB_WDATA_I(t_wd), .TB_COUNT_O(t_cnt),
    .TB_IRQ_O(t_irq));
  tmpic_far_model tmpic_far_model_i (.clk_i(clk), .fire_i(fire),
    .pulse_i(pout), .trig_o(trig), .high_o(high), .per_o(per));
  // ----------------------------------
  // Shared tasks
  // ----------------------------------
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // Cycles between two interval requests of one channel
  task itv_per(input integer ch, input [31:0] exp);
    integer n;
  begin
    n = 0;
    while (t_irq[ch] !== 1'b1 && n < 2000)
    begin
      cyc(1);
      n = n + 1;
    end
    cyc(1);
    n = 1;
    while (t_irq[ch] !== 1'b1 && n < 2000)
    begin
      cyc(1);
      n = n + 1;
    end
    chk(n, exp);
  end
  endtask
  // Bounded wait for a pulse level; the model needs one more edge
  task wait_out(input v);
    integer n;
  begin
    n = 0;
    while (pout !== v && n < 70000)
    begin
      cyc(1);
      n = n + 1;
    end
    chk(pout, v);
    cyc(2);
  end
  endtask
  task pwm_load(input [15:0] d);
  begin
    pwd = d;
    pwr = 1'b1;
    cyc(1);
    pwr = 1'b0;
  end
  endtask
  task end_sim;
  begin
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  initial
  begin
    #850000;
    failures = failures + 1;
    end_sim;
  end
  // ----------------------------------
  // Test sequence
  // ----------------------------------
  initial
  begin
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    for (k = 0; k < 4; k = k + 1)
    begin
      t_csel[2*k +: 2] = k[1:0];
      t_wd[16*k +: 16] = 16'h0002;
    end
    t_wr = 6'h3f;
    cyc(1);
    t_wr = 6'h00;
    chk(t_cnt[15:0], 32'h2);
    t_start = 6'h3f;
    itv_per(0, 32'h3);
    itv_per(1, 32'h18);
    itv_per(2, 32'h60);
    itv_per(3, 32'h180);
    t_wd[15:0] = 16'h0005;
    t_wr = 6'h01;
    cyc(1);
    t_wr = 6'h00;
    chk(t_cnt[15:0] > 16'h0002, 32'h0);
    itv_per(0, 32'h6);
    t_start = 6'h00;
    chk(refused, 32'h0);
    pwm_load(16'h0005);
    pstart = 1'b1;
    wait_out(1'b1);
    wait_out(1'b0);
    chk(high, 32'h5);
    chk(irq_count, 32'h1);
    chk(prd, 32'h0);
    pwm_load(16'h0007);
    wait_out(1'b1);
    chk(per, 32'hffff);
    wait_out(1'b0);
    chk(high, 32'h7);
    pstart = 1'b0;
    cyc(2);
    m8 = 1'b1;
    tsel = 2'h1;
    pwm_load(16'h0301);
    pstart = 1'b1;
    cyc(20);
    chk(pout, 32'h0);
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    wait_out(1'b1);
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    wait_out(1'b0);
    chk(high, 32'h6);
    wait_out(1'b1);
    chk(per, 32'h1fe);
    pstart = 1'b0;
    cyc(2);
    chk(pout, 32'h0);
    csel = 2'h1;
    tsel = 2'h2;
    pwm_load(16'h0200);
    pstart = 1'b1;
    cyc(10);
    chk(pout, 32'h0);
    ovf = 1'b1;
    cyc(1);
    ovf = 1'b0;
    wait_out(1'b1);
    wait_out(1'b0);
    chk(high, 32'h10);
    wait_out(1'b1);
    chk(per, 32'h7f8);
    end_sim;
  end
endmodule // tb_top
